// [core/timer_pwm_pkg.sv]
// constants, register map and field layouts of the pwm mode timer
package timer_pwm_pkg;
    // bus side: byte address is four times the register index
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_MODE = 10'h120;
    localparam logic [IDX_W-1:0] IDX_CTRL1 = 10'h121;
    localparam logic [IDX_W-1:0] IDX_CNT = 10'h122;
    localparam logic [IDX_W-1:0] IDX_GR_A = 10'h123;
    localparam logic [IDX_W-1:0] IDX_GR_B = 10'h124;
    localparam logic [IDX_W-1:0] IDX_GR_C = 10'h125;
    localparam logic [IDX_W-1:0] IDX_GR_D = 10'h126;
    localparam logic [IDX_W-1:0] IDX_CTRL2 = 10'h130;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // compare register slots
    localparam int GR_A = 0;
    localparam int GR_B = 1;
    localparam int GR_C = 2;
    localparam int GR_D = 3;

    // count source codes
    localparam logic [2:0] CS_DIV1 = 3'h0;
    localparam logic [2:0] CS_DIV2 = 3'h1;
    localparam logic [2:0] CS_DIV4 = 3'h2;
    localparam logic [2:0] CS_DIV8 = 3'h3;
    localparam logic [2:0] CS_DIV32 = 3'h4;
    localparam logic [2:0] CS_EXT = 3'h5;
    localparam logic [2:0] CS_FOCO = 3'h6;
    localparam logic [2:0] CS_HOCO = 3'h7;

    // prescaler taps
    localparam int DIV_W = 5;
    localparam logic [DIV_W-1:0] DIV2_MASK = 5'h01;
    localparam logic [DIV_W-1:0] DIV4_MASK = 5'h03;
    localparam logic [DIV_W-1:0] DIV8_MASK = 5'h07;
    localparam logic [DIV_W-1:0] DIV32_MASK = 5'h1f;

    // register layouts, msb first
    typedef struct packed {
        logic counter_clear_select;
        logic [2:0] clk_src;
        logic [3:0] init_lvl;
    } ctrl1_s;
    typedef struct packed {
        logic [1:0] trig_edge;
        logic stop_sel;
        logic [1:0] spare;
        logic [2:0] pol;
    } ctrl2_s;
    typedef struct packed {
        logic [2:0] pwm_en;
        logic [1:0] spare;
        logic d_buf;
        logic c_buf;
        logic count_run;
    } mode_s;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h18;
    localparam logic [7:0] CTRL2_ONES = 8'h18;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] MODE_WMASK = 8'he7;
endpackage

// [core/timer_pwm_mode_outputs.sv]
// pwm mode timer: counter, three pwm channels, axi4-lite register slave
// How it works
// RL1: three pwm channels share one period m+1
// RL2: inactive n+1 cycles, active m-n cycles
// RL3: each pin picks pwm; register a fixed period
// RL4: three-bit field selects the count source
// RL5: counter increments per source tick once started
// RL6: cleared run bit stops; pins, count hold
// RL7: stop select halts counter at period match
// RL8: requests on any compare match and overflow
// RL9: channel a level bit ignored; pin a released
// RL10: control one bits 1-3 pick initial level
// RL11: writing control one drives initial level
// RL12: software changes source and levels while stopped
// RL13: clear select resets counter at period match
// RL14: control two bits 0-2 set channel polarity
// RL15: bit 5 stops at match; trigger edge ignored
// RL16: a holds period; b, c, d change points
// RL17: buffered c feeds period, d feeds b
// RL18: change point equal period leaves level unchanged
// RL19: control two bits 3 and 4 read one
// RL20: counter readable and writable by software
// RL21: high-speed oscillator must outrun the cpu clock; here it is sampled on clk_sys and counts only below half clk_sys
// RL22: change match activates, period match deactivates, buffers load
`timescale 1ns/1ps
module timer_pwm_mode_outputs import timer_pwm_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic clk_sys, // system clock, 200 MHz
    input wire logic sys_rst, // async reset, high
    input wire logic external_count_clock_pin, // external count clock
    input wire logic fast_onchip_oscillator_clock, // fast oscillator
    input wire logic high_speed_onchip_oscillator_clock, // high-speed oscillator
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [2:0] pwm_pin_o, // chan d, c, b pin levels
    output logic [2:0] pwm_pin_oe_n, // low while driving
    output logic chan_a_pin_oe_n, // always released
    output logic [3:0] match_req, // compare match pulses d..a
    output logic overflow_req // counter overflow pulse
);
    if (CNT_W < 2 || CNT_W > 16) begin : g_chk
        $error("CNT_W must lie in 2..16");
    end

    // byte-lane merge for registers up to 16 bits
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic div_tick(input logic [DIV_W-1:0] div, input logic [DIV_W-1:0] mask);
        div_tick = (div & mask) == mask;
    endfunction

    ctrl1_s c1_r;
    ctrl2_s c2_r;
    mode_s md_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] gr_r [4];
    logic [2:0] active_r;
    logic [DIV_W-1:0] div_r;
    logic [2:0] src_s1_r, src_s2_r, src_s3_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, wdata_r;
    logic [3:0] wstrb_r;
    logic [IDX_W-1:0] aw_idx_r;
    logic [2:0] pin_o_r, pin_oe_n_r;
    logic chan_a_oe_n_r;
    logic [3:0] match_r;
    logic ovf_r;

    // write happens once both halves are held and no response is pending
    // control writes need lane 0; without it the merge would copy counter bits
    logic wr_fire, wr_c1, wr_c2, wr_md, wr_cnt, wr_hit;
    logic [15:0] wr_val;
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign wr_c1 = wr_fire && wstrb_r[0] && aw_idx_r == IDX_CTRL1;
    assign wr_c2 = wr_fire && wstrb_r[0] && aw_idx_r == IDX_CTRL2;
    assign wr_md = wr_fire && wstrb_r[0] && aw_idx_r == IDX_MODE;
    assign wr_cnt = wr_fire && aw_idx_r == IDX_CNT;
    // mapped indices answer okay even when no lane is enabled
    assign wr_hit = aw_idx_r == IDX_CTRL1 || aw_idx_r == IDX_CTRL2 || aw_idx_r == IDX_MODE
        || (aw_idx_r >= IDX_CNT && aw_idx_r <= IDX_GR_D);

    // write channel handshake, either order of address and data
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            aw_idx_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_idx_r <= s_axi_awaddr[IDX_W+1:2];
            end
            if (s_axi_wvalid && wready_r) begin
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= (wr_hit && wr_fire) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // read data, decoded from the presented address
    logic [IDX_W-1:0] ar_idx;
    logic [15:0] rd_val;
    logic rd_ok;
    assign ar_idx = s_axi_araddr[IDX_W+1:2];
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        unique case (ar_idx)
            IDX_MODE: rd_val = {8'h00, md_r};
            IDX_CTRL1: rd_val = {8'h00, c1_r};
            IDX_CTRL2: rd_val = {8'h00, c2_r | CTRL2_ONES}; // see RL19
            IDX_CNT: rd_val = 16'(cnt_r); // see RL20
            IDX_GR_A: rd_val = 16'(gr_r[GR_A]);
            IDX_GR_B: rd_val = 16'(gr_r[GR_B]);
            IDX_GR_C: rd_val = 16'(gr_r[GR_C]);
            IDX_GR_D: rd_val = 16'(gr_r[GR_D]);
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= {16'h0000, rd_val};
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    assign wr_val = wmerge(16'(cnt_r), wdata_r, wstrb_r);

    // outside clocks: two flops, then a third only for edge finding
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            src_s1_r <= '0;
            src_s2_r <= '0;
            src_s3_r <= '0;
            div_r <= '0;
        end else begin
            src_s1_r <= {high_speed_onchip_oscillator_clock, fast_onchip_oscillator_clock, external_count_clock_pin};
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
            div_r <= div_r + 1'b1;
        end
    end

    // count source select; sampled oscillators lose edges above half clk_sys
    logic [2:0] rise;
    logic tick, adv, match_a, stop_hit;
    logic [3:0] eq;
    assign rise = src_s2_r & ~src_s3_r;
    always_comb begin
        unique case (c1_r.clk_src) // see RL4
            CS_DIV1: tick = 1'b1;
            CS_DIV2: tick = div_tick(div_r, DIV2_MASK);
            CS_DIV4: tick = div_tick(div_r, DIV4_MASK);
            CS_DIV8: tick = div_tick(div_r, DIV8_MASK);
            CS_DIV32: tick = div_tick(div_r, DIV32_MASK);
            CS_EXT: tick = rise[0];
            CS_FOCO: tick = rise[1];
            CS_HOCO: tick = rise[2]; // see RL21
        endcase
    end
    assign adv = md_r.count_run && tick; // see RL5
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            eq[i] = cnt_r == gr_r[i];
        end
    end
    assign match_a = eq[GR_A];
    assign stop_hit = adv && match_a && c2_r.stop_sel; // see RL7

    // control registers; trigger edge is kept but drives nothing here
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            c1_r <= CTRL1_RST;
            c2_r <= CTRL2_RST;
        end else begin
            if (wr_c1) c1_r <= wr_val[7:0];
            if (wr_c2) c2_r <= wr_val[7:0] & ~CTRL2_ONES | CTRL2_RST; // see RL15
        end
    end

    // mode register; a software write outranks a same-cycle stop
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            md_r <= MODE_RST;
        end else begin
            if (stop_hit) md_r.count_run <= 1'b0; // see RL7
            if (wr_md) md_r <= wr_val[7:0] & MODE_WMASK; // see RL3
        end
    end

    // counter: holds while stopped, software write wins
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else begin
            if (adv) begin
                if (match_a && c1_r.counter_clear_select) cnt_r <= '0; // see RL13
                else if (!stop_hit) cnt_r <= cnt_r + 1'b1; // see RL1 RL6
            end
            if (wr_cnt) cnt_r <= wr_val[CNT_W-1:0]; // see RL20
        end
    end

    // compare registers with buffered loads at the period match
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) gr_r[i] <= '1;
        end else begin
            if (adv && match_a && md_r.c_buf) gr_r[GR_A] <= gr_r[GR_C]; // see RL17 RL22
            if (adv && match_a && md_r.d_buf) gr_r[GR_B] <= gr_r[GR_D]; // see RL17
            for (int i = 0; i < 4; i++) begin
                if (wr_fire && aw_idx_r == IDX_GR_A + IDX_W'(i)) begin
                    // size cast trims the merged word to the counter width
                    gr_r[i] <= CNT_W'(wmerge(16'(gr_r[i]), wdata_r, wstrb_r)); // see RL16
                end
            end
        end
    end

    // channel state; a control one write reloads the initial level
    logic [2:0] ch_on;
    assign ch_on = {!md_r.d_buf, !md_r.c_buf, 1'b1}; // see RL16
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            active_r <= '0;
        end else if (wr_c1) begin
            active_r <= wr_val[3:1]; // see RL10 RL11
        end else if (adv) begin
            for (int i = 0; i < 3; i++) begin
                if (ch_on[i] && !eq[GR_B+i] || !match_a) begin
                    if (ch_on[i] && gr_r[GR_B+i] != gr_r[GR_A]) begin // see RL18
                        if (match_a) active_r[i] <= 1'b0; // see RL22
                        else if (eq[GR_B+i]) active_r[i] <= 1'b1; // see RL2
                    end
                end else if (ch_on[i] && gr_r[GR_B+i] != gr_r[GR_A]) begin
                    active_r[i] <= 1'b0;
                end
            end
        end
    end

    // pins and requests; channel a level bit is deliberately unused
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_o_r <= '0;
            pin_oe_n_r <= '1;
            chan_a_oe_n_r <= 1'b1;
            match_r <= '0;
            ovf_r <= 1'b0;
        end else begin
            pin_o_r <= active_r ~^ c2_r.pol; // see RL14
            pin_oe_n_r <= ~md_r.pwm_en; // see RL3
            chan_a_oe_n_r <= 1'b1; // see RL9
            match_r <= adv ? eq : 4'h0; // see RL8
            ovf_r <= adv && &cnt_r && !(match_a && (c1_r.counter_clear_select || c2_r.stop_sel)); // see RL8
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pwm_pin_o = pin_o_r;
    assign pwm_pin_oe_n = pin_oe_n_r;
    assign chan_a_pin_oe_n = chan_a_oe_n_r;
    assign match_req = match_r;
    assign overflow_req = ovf_r;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    run_start_a: assert property (wr_md && wr_val[0] |=> md_r.count_run) else $error("run bit not set"); // see RL5
    stop_match_a: assert property (stop_hit && !wr_md |=> !md_r.count_run) else $error("no stop at period"); // see RL7
    hold_stopped_a: assert property (!md_r.count_run && !wr_cnt && !wr_md |=> $stable(cnt_r))
        else $error("counter moved while stopped"); // see RL6
    clear_counter_clear_select_a: assert property (adv && match_a && c1_r.counter_clear_select && !wr_cnt |=> cnt_r == '0)
        else $error("counter not cleared"); // see RL13
    chan_on_a: assert property (adv && eq[GR_B] && !match_a && !wr_c1 |=> active_r[0])
        else $error("channel b not active"); // see RL2
    chan_off_a: assert property (adv && match_a && gr_r[GR_B] != gr_r[GR_A] && !wr_c1 |=> !active_r[0])
        else $error("channel b not inactive"); // see RL22
    full_duty_a: assert property (adv && gr_r[GR_B] == gr_r[GR_A] && !wr_c1 |=> $stable(active_r[0]))
        else $error("level moved at equal compare"); // see RL18
    init_level_a: assert property (wr_c1 |=> ##1 pwm_pin_o == ($past(wr_val[3:1], 2) ~^ c2_r.pol))
        else $error("initial level not driven"); // see RL11
    buf_load_a: assert property (adv && match_a && md_r.c_buf && !wr_fire |=> gr_r[GR_A] == $past(gr_r[GR_C]))
        else $error("period buffer not loaded"); // see RL17
    match_req_a: assert property (adv && match_a |=> match_req[GR_A]) else $error("no period match request"); // see RL8
    pin_a_a: assert property (##1 chan_a_pin_oe_n) else $error("pin a driven"); // see RL9

    stop_cov_c: cover property (stop_hit);
    buffer_cov_c: cover property (adv && match_a && md_r.d_buf);
    overflow_cov_c: cover property (overflow_req);
endmodule

// [tb/pwm_load_model.sv]
// load model: external loads on the three pwm pins
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic clk_sys, // system clock
    input wire logic [2:0] pin_lvl, // driven levels d,c,b
    input wire logic [2:0] pin_oe_n, // low while driven
    input wire logic clr, // restart the tallies
    output int high_b, // cycles chan b high
    output int high_c, // cycles chan c high
    output int high_d, // cycles chan d high
    output int rise_b // rising edges on chan b
);
    logic [2:0] wire_lvl;
    logic prev_b = 1'b1;
    // a released pin floats up through the load's pull-up
    assign wire_lvl = pin_lvl | pin_oe_n;
    // tally levels and edges, one sample per clock
    always @(posedge clk_sys) begin
        prev_b <= wire_lvl[0];
        if (clr) begin
            high_b <= 0;
            high_c <= 0;
            high_d <= 0;
            rise_b <= 0;
        end else begin
            high_b <= high_b + int'(wire_lvl[0]);
            high_c <= high_c + int'(wire_lvl[1]);
            high_d <= high_d + int'(wire_lvl[2]);
            rise_b <= rise_b + int'(wire_lvl[0] && !prev_b);
        end
    end
endmodule

// [tb/timer_pwm_mode_outputs_test.sv]
// self-checking bench for the pwm mode timer
`timescale 1ns/1ps
module timer_pwm_mode_outputs_test import timer_pwm_pkg::*;;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clr = 1'b0;
    logic [7:0] gen_cnt = 8'h00;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, a_oe_n, ovf;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] pin_o, pin_oe_n;
    logic [3:0] match;
    logic [7:0] c1;
    int miscompares = 0, tests_run = 0, hb, hc, hd, rb, m_a = 0, m_all = 0, n_ovf = 0;
    int per [8] = '{1, 2, 4, 8, 32, 8, 16, 4}; // clocks per count tick, by source code

    // 200 MHz system clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // slow count sources and tallies of request pulses
    always @(posedge clk_sys) begin
        gen_cnt <= gen_cnt + 8'h01;
        m_a <= clr ? 0 : m_a + int'(match[0]);
        m_all <= clr ? 0 : m_all + $countones(match);
        n_ovf <= clr ? 0 : n_ovf + int'(ovf);
    end

    timer_pwm_mode_outputs #(.CNT_W(8)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .external_count_clock_pin(gen_cnt[2]),
        .fast_onchip_oscillator_clock(gen_cnt[3]), .high_speed_onchip_oscillator_clock(gen_cnt[1]),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_pin_o(pin_o), .pwm_pin_oe_n(pin_oe_n), .chan_a_pin_oe_n(a_oe_n),
        .match_req(match), .overflow_req(ovf)
    );

    pwm_load_model LOAD (
        .clk_sys(clk_sys), .pin_lvl(pin_o), .pin_oe_n(pin_oe_n), .clr(clr),
        .high_b(hb), .high_c(hc), .high_d(hd), .rise_b(rb)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
        int n = 0;
        @(posedge clk_sys);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge clk_sys);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                n = 99;
            end
        end
        if (n < 99) begin
            chk(n, 99);
            summarize();
        end
    endtask

    task automatic rd(input logic [IDX_W-1:0] idx, output logic [7:0] v);
        int n = 0;
        @(posedge clk_sys);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge clk_sys);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata[7:0];
                resp = rresp;
                rready <= 1'b0;
                n = 99;
            end
        end
        if (n < 99) begin
            chk(n, 99);
            summarize();
        end
    endtask

    task automatic rc(input logic [IDX_W-1:0] idx, input logic [7:0] e);
        logic [7:0] v;
        rd(idx, v);
        chk(32'(v), 32'(e));
    endtask

    // off-edge pause so registered outputs have settled
    task automatic pause(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // window of exactly cyc samples in the load tallies
    task automatic meas(input int cyc);
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        pause(cyc);
    endtask

    task automatic tend(input string s);
        $display("test %s finished", s);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, nearly four times the expected run
    initial begin
        repeat (30000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rc(IDX_CTRL1, 8'h00);
        rc(IDX_CTRL2, 8'h18);
        rc(IDX_MODE, 8'h00);
        rc(IDX_CNT, 8'h00);
        rc(IDX_GR_A, 8'hff);
        rc(10'h1ff, 8'h00);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(10'h1ff, 8'h55);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(IDX_CTRL2, 8'h00);
        chk(32'(resp), 32'(RESP_OKAY));
        rc(IDX_CTRL2, 8'h18);
        wr(IDX_CTRL1, 8'h01);
        pause(2);
        chk(32'(a_oe_n), 32'h1);
        chk(32'(pin_oe_n), 32'h7);
        tend("registers");
        // period 4, b at n=1, c at n=0, d with change point equal to period
        wr(IDX_GR_A, 8'h03);
        wr(IDX_GR_B, 8'h01);
        wr(IDX_GR_C, 8'h00);
        wr(IDX_GR_D, 8'h03);
        wr(IDX_CTRL2, 8'h03);
        wr(IDX_CTRL1, 8'h88);
        wr(IDX_MODE, 8'he1);
        meas(40);
        chk(32'(pin_oe_n), 32'h0);
        chk(rb, 32'ha);
        chk(hb, 32'h14);
        chk(hc, 32'h1e);
        chk(hd, 32'h0);
        tend("waveforms");
        // every count source, period measured in rising edges
        for (int cs = 0; cs < 8; cs++) begin
            wr(IDX_MODE, 8'he0);
            wr(IDX_CTRL1, 8'h80 | 8'(cs << 4));
            wr(IDX_MODE, 8'he1);
            pause(300);
            meas(512);
            chk(rb, 512 / (4 * per[cs]));
        end
        tend("sources");
        wr(IDX_MODE, 8'he0);
        wr(IDX_CTRL1, 8'h80);
        rd(IDX_CNT, c1);
        meas(20);
        chk(rb, 32'h0);
        chk(hb % 20, 32'h0);
        rc(IDX_CNT, c1);
        wr(IDX_CNT, 8'h02);
        rc(IDX_CNT, 8'h02);
        tend("stop");
        // stop at period match, no clearing, trigger edge bits set but ignored
        wr(IDX_CTRL1, 8'h00);
        wr(IDX_CTRL2, 8'he3);
        wr(IDX_MODE, 8'he1);
        pause(20);
        rc(IDX_MODE, 8'he0);
        rc(IDX_CNT, 8'h03);
        chk(32'(pin_o[0]), 32'h0);
        tend("stop select");
        wr(IDX_CTRL2, 8'h03);
        wr(IDX_CNT, 8'h00);
        wr(IDX_MODE, 8'he1);
        meas(1024);
        chk(n_ovf, 32'h4);
        chk(m_a, 32'h4);
        chk(m_all, 32'h10);
        tend("requests");
        wr(IDX_MODE, 8'he0);
        wr(IDX_CTRL2, 8'h07);
        wr(IDX_CTRL1, 8'h0e);
        pause(2);
        chk(32'(pin_o), 32'h7);
        wr(IDX_CTRL2, 8'h00);
        wr(IDX_CTRL1, 8'h04);
        pause(2);
        chk(32'(pin_o), 32'h5);
        tend("initial levels");
        // buffered period 8 and buffered change point 5 on chan b
        wr(IDX_CTRL2, 8'h01);
        wr(IDX_CTRL1, 8'h80);
        wr(IDX_GR_A, 8'h03);
        wr(IDX_GR_B, 8'h01);
        wr(IDX_GR_C, 8'h07);
        wr(IDX_GR_D, 8'h05);
        wr(IDX_CNT, 8'h00);
        wr(IDX_MODE, 8'h27);
        pause(50);
        meas(64);
        chk(32'(pin_oe_n), 32'h6);
        chk(rb, 32'h8);
        chk(hb, 32'h10);
        rc(IDX_GR_A, 8'h07);
        rc(IDX_GR_B, 8'h05);
        tend("buffers");
        summarize();
    end
endmodule
